// ### hw/shc_serial_handshake.v
// modem and flow control for the serial side of a serial to network server
// How it works
// R1: carrier detect and ring indicator inputs are ignored completely.
// R2: characters go out only when queued and not flowed off.
// R3: terminal ready stays low after reset until a connection exists.
// R4: terminal ready rises on connection, falls on disconnection.
// R5: hardware dial without forced on connects when data set ready asserts.
// R6: hardware dial with forced on connects as soon as it is selected, without waiting for data set ready.
// R7: command dial from interface connects only if data set ready already high.
// R8: as server, an incoming connection is accepted only with data set ready high.
// R9: request to send drops when buffer fill reaches the flow off level.
// R10: request to send rises again once fill falls to the flow on level.
// R11: with hardware flow control, clear to send low halts transmission.
// R12: the serial receive buffer holds 4 Kbytes.
// R13: server drops link on data set ready low or three idle minutes.
// R14: flow on level should sit below flow off level for hysteresis.
`timescale 1ns/1ps
`include "shc_regs.vh"
module shc_serial_handshake #(
  parameter AW = 12,
  parameter IDLE_CYCLES = 64'd45000000000
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire carrier_detect,
  input wire ring_indicator,
  input wire data_set_ready,
  input wire clear_to_send,
  output reg data_terminal_ready,
  output reg request_to_send,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire [7:0] tx_char_in,
  input wire tx_char_valid,
  output reg tx_char_taken,
  output reg [7:0] tx_data,
  output reg tx_valid,
  input wire tx_ready,
  output reg [7:0] buf_data,
  output reg buf_valid,
  input wire buf_ready,
  output reg net_open_req,
  output reg net_close_req,
  output reg net_accept_ok
);
  localparam [AW:0] CAP = {1'b1, {AW{1'b0}}};
  // fill arithmetic helper: clamp a 16-bit level to the buffer capacity
  function [AW:0] shc_level;
    input [15:0] lvl;
    begin
      if ({16'h0000, lvl} >= {{(32-AW-1){1'b0}}, CAP}) begin
        shc_level = CAP;
      end else begin
        shc_level = lvl[AW:0];
      end
    end
  endfunction
  // register file
  reg [31:0] ctrl_q;
  reg [31:0] flow_q;
  wire [1:0] dial_mode = ctrl_q[`SHC_CTRL_DIAL_HI:`SHC_CTRL_DIAL_LO];
  wire forced_on = ctrl_q[`SHC_CTRL_FORCED];
  wire from_if = ctrl_q[`SHC_CTRL_FROM_IF];
  wire server_mode = ctrl_q[`SHC_CTRL_SERVER];
  wire [1:0] flow_mode = ctrl_q[`SHC_CTRL_FLOW_HI:`SHC_CTRL_FLOW_LO];
  wire [AW:0] off_lvl = shc_level(flow_q[`SHC_FLOW_OFF_LO+15:`SHC_FLOW_OFF_LO]);
  wire [AW:0] on_lvl = shc_level(flow_q[`SHC_FLOW_ON_LO+15:`SHC_FLOW_ON_LO]);
  // axi write channel capture
  reg aw_have_q;
  reg w_have_q;
  reg [3:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  reg cmd_pulse_q;
  reg hang_pulse_q;
  reg up_pulse_q;
  reg down_pulse_q;
  reg pkt_pulse_q;
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SHC_RESP_OK;
      ctrl_q <= `SHC_CTRL_RST;
      flow_q <= `SHC_FLOW_RST;
      cmd_pulse_q <= 1'b0;
      hang_pulse_q <= 1'b0;
      up_pulse_q <= 1'b0;
      down_pulse_q <= 1'b0;
      pkt_pulse_q <= 1'b0;
    end else begin
      cmd_pulse_q <= 1'b0;
      hang_pulse_q <= 1'b0;
      up_pulse_q <= 1'b0;
      down_pulse_q <= 1'b0;
      pkt_pulse_q <= 1'b0;
      // both readies stay low while a write answer is still pending
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SHC_RESP_OK;
        case ({aw_addr_q[3:2], 2'b00})
          `SHC_CTRL_OFS: begin
            for (i = 0; i < 4; i = i + 1) begin
              if (w_strb_q[i]) begin
                ctrl_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
              end
            end
            // command strobes are self clearing
            cmd_pulse_q <= w_strb_q[0] && w_data_q[`SHC_CTRL_DIAL_CMD];
            hang_pulse_q <= w_strb_q[1] && w_data_q[`SHC_CTRL_HANGUP];
            up_pulse_q <= w_strb_q[1] && w_data_q[`SHC_CTRL_NET_UP];
            down_pulse_q <= w_strb_q[1] && w_data_q[`SHC_CTRL_NET_DOWN];
            pkt_pulse_q <= w_strb_q[1] && w_data_q[`SHC_CTRL_PKT];
          end
          `SHC_FLOW_OFS: begin
            for (i = 0; i < 4; i = i + 1) begin
              if (w_strb_q[i]) begin
                flow_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
              end
            end
          end
          default: begin
            s_axi_bresp <= `SHC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        ctrl_q[`SHC_CTRL_PKT:`SHC_CTRL_DIAL_CMD] <= 5'h00;
      end
    end
  end
  // connection state machine
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_OPEN = 2'h1;
  localparam [1:0] ST_UP = 2'h2;
  reg [1:0] state_q;
  reg [63:0] idle_q;
  wire drop_now = down_pulse_q || hang_pulse_q ||
    (server_mode && !data_set_ready) || // see R13
    (server_mode && idle_q >= IDLE_CYCLES) || // see R13
    (!server_mode && dial_mode == `SHC_DIAL_HW && !forced_on && !data_set_ready);
  // decide whether a client should start a connection
  reg want_open;
  always @* begin
    want_open = 1'b0;
    case (dial_mode)
      `SHC_DIAL_HW: want_open = forced_on || data_set_ready; // see R5 R6
      `SHC_DIAL_CMD: want_open = cmd_pulse_q && (!from_if || data_set_ready); // see R7
      default: want_open = 1'b0;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      data_terminal_ready <= 1'b0; // see R3
      net_open_req <= 1'b0;
      net_close_req <= 1'b0;
      net_accept_ok <= 1'b0;
      idle_q <= 64'h0;
    end else begin
      net_close_req <= 1'b0;
      net_accept_ok <= server_mode && data_set_ready; // see R8
      case (state_q)
        ST_IDLE: begin
          idle_q <= 64'h0;
          net_open_req <= 1'b0;
          if (server_mode) begin
            if (up_pulse_q && data_set_ready) begin // see R8
              state_q <= ST_UP;
              data_terminal_ready <= 1'b1; // see R4
            end
          end else if (want_open) begin
            state_q <= ST_OPEN;
            net_open_req <= 1'b1;
          end
        end
        ST_OPEN: begin
          if (up_pulse_q) begin
            state_q <= ST_UP;
            net_open_req <= 1'b0;
            data_terminal_ready <= 1'b1; // see R4
          end else if (down_pulse_q || hang_pulse_q) begin
            state_q <= ST_IDLE;
            net_open_req <= 1'b0;
          end
        end
        ST_UP: begin
          idle_q <= pkt_pulse_q ? 64'h0 : idle_q + 64'h1;
          if (drop_now) begin
            state_q <= ST_IDLE;
            data_terminal_ready <= 1'b0; // see R4
            net_close_req <= !down_pulse_q;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          data_terminal_ready <= 1'b0;
        end
      endcase
    end
  end
  // receive buffer: 4 Kbytes of storage with fill count, see R12
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] fill_q;
  reg rd_pend_q;
  wire [7:0] mem_q;
  wire push = rx_valid && (fill_q != CAP);
  wire out_free = !buf_valid || buf_ready;
  wire pop = (fill_q != {(AW+1){1'b0}}) && !rd_pend_q && out_free;
  shc_buf_mem #(.AW(AW)) u_mem (
    .aclk(aclk),
    .wr_en(push),
    .wr_addr(wp_q),
    .wr_data(rx_data),
    .rd_addr(rp_q),
    .rd_data(mem_q)
  );
  always @(posedge aclk) begin
    if (!aresetn) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      fill_q <= {(AW+1){1'b0}};
      rd_pend_q <= 1'b0;
      buf_valid <= 1'b0;
      buf_data <= 8'h00;
      request_to_send <= 1'b1;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      fill_q <= fill_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      rd_pend_q <= pop;
      if (rd_pend_q) begin
        buf_valid <= 1'b1;
        buf_data <= mem_q;
      end else if (buf_ready) begin
        buf_valid <= 1'b0;
      end
      // hysteresis on the fill level, see R14
      if (fill_q >= off_lvl) begin
        request_to_send <= 1'b0; // see R9
      end else if (fill_q <= on_lvl) begin
        request_to_send <= 1'b1; // see R10
      end
    end
  end
  // transmit gate with xon/xoff state
  reg xoff_q;
  wire sw_rx_ctl = (flow_mode == `SHC_FLOW_SW) && rx_valid;
  wire flowed_off = ((flow_mode == `SHC_FLOW_SW) && xoff_q) ||
    ((flow_mode == `SHC_FLOW_HW) && !clear_to_send); // see R11
  wire tx_go = tx_char_valid && !flowed_off && (!tx_valid || tx_ready) && !tx_char_taken;
  always @(posedge aclk) begin
    if (!aresetn) begin
      xoff_q <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_char_taken <= 1'b0;
    end else begin
      if (sw_rx_ctl && rx_data == `SHC_XOFF) begin
        xoff_q <= 1'b1;
      end else if ((sw_rx_ctl && rx_data == `SHC_XON) || flow_mode != `SHC_FLOW_SW) begin
        xoff_q <= 1'b0;
      end
      tx_char_taken <= tx_go;
      if (tx_go) begin
        tx_valid <= 1'b1; // see R2
        tx_data <= tx_char_in;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
    end
  end
  // axi read channel; carrier detect and ring indicator never read, see R1
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SHC_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SHC_RESP_OK;
        case ({s_axi_araddr[3:2], 2'b00})
          `SHC_CTRL_OFS: s_axi_rdata <= ctrl_q;
          `SHC_STAT_OFS: s_axi_rdata <= {24'h0, xoff_q, request_to_send, clear_to_send,
            data_set_ready, data_terminal_ready, net_open_req, state_q};
          `SHC_FLOW_OFS: s_axi_rdata <= flow_q;
          `SHC_FILL_OFS: s_axi_rdata <= {{(31-AW){1'b0}}, fill_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SHC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // shc_serial_handshake

// ### hw/shc_regs.vh
// register offsets, field positions, reset values and timing for the handshake control block
`ifndef SHC_REGS_VH
`define SHC_REGS_VH
// register byte offsets
`define SHC_CTRL_OFS 4'h0
`define SHC_STAT_OFS 4'h4
`define SHC_FLOW_OFS 4'h8
`define SHC_FILL_OFS 4'hc
// control register fields
`define SHC_CTRL_DIAL_LO 0
`define SHC_CTRL_DIAL_HI 1
`define SHC_CTRL_FORCED 2
`define SHC_CTRL_FROM_IF 3
`define SHC_CTRL_SERVER 4
`define SHC_CTRL_FLOW_LO 5
`define SHC_CTRL_FLOW_HI 6
`define SHC_CTRL_DIAL_CMD 7
`define SHC_CTRL_HANGUP 8
`define SHC_CTRL_NET_UP 9
`define SHC_CTRL_NET_DOWN 10
`define SHC_CTRL_PKT 11
`define SHC_CTRL_RST 32'h0000_0000
// flow level register fields
`define SHC_FLOW_OFF_LO 0
`define SHC_FLOW_ON_LO 16
`define SHC_FLOW_RST 32'h0c00_0e00
// dial settings
`define SHC_DIAL_NONE 2'h0
`define SHC_DIAL_HW 2'h1
`define SHC_DIAL_CMD 2'h2
// flow control settings
`define SHC_FLOW_NONE 2'h0
`define SHC_FLOW_HW 2'h1
`define SHC_FLOW_SW 2'h2
// xon and xoff characters
`define SHC_XON 8'h11
`define SHC_XOFF 8'h13
// buffer size and idle time
`define SHC_BUF_BYTES 4096
`define SHC_IDLE_S 180
`define SHC_CLK_HZ 250000000
// axi responses
`define SHC_RESP_OK 2'h0
`define SHC_RESP_SLVERR 2'h2
`endif

// ### hw/shc_buf_mem.v
// byte store for the serial receive buffer, registered read
`timescale 1ns/1ps
module shc_buf_mem #(
  parameter AW = 12
) (
  input wire aclk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] mem [0:(1<<AW)-1];
  // write port and registered read port
  always @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // shc_buf_mem

// ### test/shc_sva.sv
// port-level assertions for the serial handshake block
`timescale 1ns/1ps
module shc_sva (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire data_set_ready,
  input wire data_terminal_ready,
  input wire request_to_send,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire [7:0] buf_data,
  input wire buf_valid,
  input wire buf_ready,
  input wire net_accept_ok,
  input wire net_close_req
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // reset leaves the modem lines idle
  chk_reset_idle: assert property (
    disable iff (1'b0) !aresetn |=> !data_terminal_ready && request_to_send && !tx_valid)
    else $error("lines not idle after reset");
  // answers and transfers hold until taken
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer moved");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer moved");
  chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("serial char moved");
  chk_buf_hold: assert property (
    buf_valid && !buf_ready |=> buf_valid && $stable(buf_data))
    else $error("buffer byte moved");
  // server accept follows the ready input, drop request is a single pulse
  chk_accept_dsr: assert property (!data_set_ready |=> !net_accept_ok)
    else $error("accept without ready input");
  chk_close_pulse: assert property (net_close_req |=> !net_close_req)
    else $error("drop request too long");
endmodule // shc_sva

bind shc_serial_handshake shc_sva chk (.*);

// ### test/shc_term_model.sv
// attached serial terminal: modem lines, received bytes, transmit pacing
`timescale 1ns/1ps
module shc_term_model (
  input wire aclk,
  output logic data_set_ready,
  output logic clear_to_send,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic tx_ready
);
  logic slow = 1'b0;
  initial begin
    {data_set_ready, rx_valid, rx_data} = 10'h000;
    {clear_to_send, tx_ready} = 2'h3;
  end
  // ready is raised before dialling, clear is dropped to pause the device
  task automatic set_lines(input logic dsr_lvl, input logic cts_lvl);
    data_set_ready <= dsr_lvl;
    clear_to_send <= cts_lvl;
  endtask
  // one byte, then the line shows its inverse so stale data never matches
  task automatic send(input logic [7:0] c);
    rx_data <= c;
    rx_valid <= 1'b1;
    @(posedge aclk);
    rx_data <= ~c;
    rx_valid <= 1'b0;
    @(posedge aclk);
  endtask
  // a slow receiver takes a character every other cycle
  always @(posedge aclk)
    tx_ready <= slow ? ~tx_ready : 1'b1;
endmodule // shc_term_model

// ### test/tb.sv
// self-checking bench for the serial handshake block
`timescale 1ns/1ps
`include "shc_regs.vh"
module tb;
  logic aclk, aresetn, carrier_detect, ring_indicator, tx_char_valid, buf_ready;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, v;
  logic [7:0] tx_char_in, b;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_valid;
  wire data_set_ready, clear_to_send, data_terminal_ready, request_to_send, tx_char_taken;
  wire tx_valid, tx_ready, buf_valid, net_open_req, net_close_req, net_accept_ok;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] rx_data, tx_data, buf_data;
  int n_errors = 0;
  int total_checks = 0;
  shc_serial_handshake #(.IDLE_CYCLES(64'd50)) dut (.*);
  shc_term_model term (.aclk, .data_set_ready, .clear_to_send, .rx_data, .rx_valid, .tx_ready);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    {aresetn, carrier_detect, ring_indicator, tx_char_valid, buf_ready, tx_char_in} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
  end
  // a queued character is withdrawn once taken
  always @(posedge aclk)
    if (tx_char_taken) tx_char_valid <= 1'b0;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic give_up;
    n_errors++;
    report_and_stop();
  endtask
  function automatic logic sig(input int i);
    return i == 0 ? data_terminal_ready : i == 1 ? request_to_send : i == 2 ? net_open_req :
      i == 3 ? net_accept_ok : i == 4 ? net_close_req : tx_valid;
  endfunction
  // waits for a line level, or with hold checks it stays for 20 cycles
  task automatic see(input int i, input logic e, input bit hold = 1'b0);
    int n;
    for (n = 0; n < 300 && (hold ? n < 20 : sig(i) !== e); n++) begin
      @(posedge aclk);
      if (hold) chk($sformatf("line %0d", i), e, sig(i));
    end
    chk($sformatf("line %0d", i), e, sig(i));
    if (n == 300) report_and_stop();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    if (n == 50) give_up();
  endtask
  task automatic rd(input logic [3:0] a);
    int n;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (n == 50) give_up();
  endtask
  // takes k bytes from the buffer, keeping the first
  task automatic drain(input int k);
    int c, n;
    c = 0;
    buf_ready <= 1'b1;
    for (n = 0; n < 9000 && c < k; n++) begin
      @(posedge aclk);
      if (buf_valid && buf_ready) begin
        if (c == 0) b = buf_data;
        c++;
      end
    end
    buf_ready <= 1'b0;
    if (c < k) give_up();
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    term.set_lines(1'b0, 1'b1);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic t_regs;
    rst();
    chk("dtr", 1'b0, data_terminal_ready);
    rd(4'h8);
    chk("flow", `SHC_FLOW_RST, v);
    chk("rresp", `SHC_RESP_OK, r);
    rd(4'h4);
    chk("stat", 32'h0000_0060, v);
    wr(4'hc, 32'hffff_ffff);
    chk("bresp", `SHC_RESP_SLVERR, r);
    rd(4'hc);
    chk("fill", 32'h0, v);
  endtask
  task automatic t_hw_dial;
    rst();
    wr(4'h0, 32'h1);
    {carrier_detect, ring_indicator} <= 2'h3;
    see(2, 1'b0, 1'b1);
    term.set_lines(1'b1, 1'b1);
    see(2, 1'b1);
    wr(4'h0, 32'h201);
    see(0, 1'b1);
    carrier_detect <= 1'b0;
    see(0, 1'b1, 1'b1);
    wr(4'h0, 32'h401);
    see(0, 1'b0);
  endtask
  task automatic t_forced;
    rst();
    wr(4'h0, 32'h5);
    see(2, 1'b1);
  endtask
  task automatic t_cmd;
    rst();
    wr(4'h0, 32'h8a);
    see(2, 1'b0, 1'b1);
    term.set_lines(1'b1, 1'b1);
    wr(4'h0, 32'h8a);
    see(2, 1'b1);
    wr(4'h0, 32'h10a);
    see(2, 1'b0);
  endtask
  task automatic t_server;
    rst();
    wr(4'h0, 32'h10);
    see(3, 1'b0, 1'b1);
    term.set_lines(1'b1, 1'b1);
    see(3, 1'b1);
    wr(4'h0, 32'h210);
    see(0, 1'b1);
    repeat (36) @(posedge aclk);
    wr(4'h0, 32'h810);
    see(0, 1'b1, 1'b1);
    see(4, 1'b1);
    see(0, 1'b0);
    wr(4'h0, 32'h210);
    see(0, 1'b1);
    term.set_lines(1'b0, 1'b1);
    repeat (2) @(posedge aclk);
    chk("close", 1'b1, net_close_req);
    see(0, 1'b0);
  endtask
  task automatic t_flow;
    rst();
    wr(4'h8, 32'h0004_0008);
    wr(4'h0, 32'h20);
    for (int i = 0; i < 9; i++) term.send(8'h30 + 8'(i));
    see(1, 1'b0);
    drain(3);
    chk("first byte", 8'h30, b);
    see(1, 1'b0, 1'b1);
    drain(1);
    see(1, 1'b1);
    wr(4'h0, 32'h0);
    for (int i = 0; i < 4094; i++) term.send(8'(i));
    rd(4'hc);
    chk("fill", `SHC_BUF_BYTES, v);
    drain(`SHC_BUF_BYTES);
    rd(4'hc);
    chk("fill", 32'h0, v);
  endtask
  task automatic t_tx;
    rst();
    term.set_lines(1'b1, 1'b0);
    term.slow <= 1'b1;
    wr(4'h0, 32'h20);
    {tx_char_in, tx_char_valid} <= {8'h41, 1'b1};
    see(5, 1'b0, 1'b1);
    term.set_lines(1'b1, 1'b1);
    see(5, 1'b1);
    chk("tx data", 8'h41, tx_data);
    see(5, 1'b0);
    wr(4'h0, 32'h40);
    term.send(`SHC_XOFF);
    {tx_char_in, tx_char_valid} <= {8'h42, 1'b1};
    see(5, 1'b0, 1'b1);
    term.send(`SHC_XON);
    see(5, 1'b1);
    chk("tx data", 8'h42, tx_data);
  endtask
  initial begin
    @(posedge aclk);
    t_regs();
    t_hw_dial();
    t_forced();
    t_cmd();
    t_server();
    t_flow();
    t_tx();
    report_and_stop();
  end
endmodule // tb
